// ### hdl/gcc_cmd_handler.sv
`include "gcc_defs.svh"
`default_nettype none
module gcc_cmd_handler (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic tx_room,
  input wire logic add_valid,
  input wire logic [`GCC_TBL_AW-1:0] add_index,
  input wire logic [7:0] add_ep,
  input wire logic [15:0] add_gid,
  output logic add_ready
);
  gcc_pkg::gcc_regs_t r_ff;
  gcc_pkg::gcc_regs_t nxt_r;
  gcc_tbl_if tbl ();

  gcc_group_table u_tbl (
    .core_clk(core_clk),
    .rst(rst),
    .port(tbl.mem)
  );

  function automatic logic [7:0] rpl_byte(input gcc_pkg::gcc_regs_t r, input logic [4:0] i);
    logic [7:0] b;
    int ofs;
    b = 8'h00;
    ofs = 0;
    if (i == 5'h00) begin
      b = `GCC_API_EXPL_RX;
    end else if (i <= 5'h0A) begin
      ofs = (10 - int'(i)) * 8;
      b = r.addr[ofs +: 8];
    end else if (i == 5'h0B) begin
      b = r.dst_ep;
    end else if (i == 5'h0C) begin
      b = r.src_ep;
    end else if (i == 5'h0D) begin
      b = 8'(`GCC_CLUSTER_GRP_RSP >> 8);
    end else if (i == 5'h0E) begin
      b = 8'(`GCC_CLUSTER_GRP_RSP);
    end else if (i == 5'h0F) begin
      b = 8'(`GCC_PROFILE >> 8);
    end else if (i == 5'h10) begin
      b = 8'(`GCC_PROFILE);
    end else if (i == 5'h11) begin
      b = `GCC_RPL_OPTIONS;
    end else begin
      ofs = 40 - (int'(i) - int'(`GCC_RPL_HDR_LEN)) * 8;
      b = r.rz[ofs +: 8];
    end
    return b;
  endfunction : rpl_byte

  function automatic logic [7:0] stat_byte(input gcc_pkg::gcc_regs_t r, input logic [4:0] i);
    logic [7:0] b;
    unique case (i)
      5'h00: b = `GCC_API_TX_STAT;
      5'h01: b = r.tag;
      5'h02: b = 8'(`GCC_ADDR16_UNKNOWN >> 8);
      5'h03: b = 8'(`GCC_ADDR16_UNKNOWN);
      default: b = `GCC_STAT_ZERO;
    endcase
    return b;
  endfunction : stat_byte

  function automatic logic [47:0] dflt_rsp(input gcc_pkg::gcc_regs_t r, input logic [7:0] code);
    return {`GCC_FC_RSP_GENERAL, r.seq, `GCC_CMD_DEFAULT_RSP, r.cmd, code, 8'h00};
  endfunction : dflt_rsp

  always_comb begin
    logic [7:0] fc;
    logic [4:0] last;
    logic match;
    fc = r_ff.fc;
    last = 5'h00;
    match = 1'b0;
    nxt_r = r_ff;
    tbl.we = 1'b0;
    tbl.waddr = add_index;
    tbl.wdata = '{valid: 1'b1, ep: add_ep, gid: add_gid};
    tbl.raddr = r_ff.idx;
    // Table loads only while no scan can write the same array
    if (add_valid && r_ff.add_ready) begin
      tbl.we = 1'b1;
    end
    unique case (r_ff.st)
      gcc_pkg::GCC_RECV: begin
        if (rx_valid && r_ff.rx_ready) begin
          if (r_ff.hcnt == `GCC_OFS_TYPE) begin
            nxt_r.zlen = 3'h0;
            nxt_r.fc = 8'h00;
            nxt_r.seq = 8'h00;
            nxt_r.cmd = 8'h00;
            nxt_r.glo = 8'h00;
            nxt_r.ghi = 8'h00;
            nxt_r.ftype = rx_data;
          end else if (r_ff.hcnt == `GCC_OFS_TAG) begin
            nxt_r.tag = rx_data;
          end else if (r_ff.hcnt <= `GCC_OFS_ADDR_HI) begin
            nxt_r.addr = {r_ff.addr[71:0], rx_data};
          end else if (r_ff.hcnt == `GCC_OFS_SRC_EP) begin
            nxt_r.src_ep = rx_data;
          end else if (r_ff.hcnt == `GCC_OFS_DST_EP) begin
            nxt_r.dst_ep = rx_data;
          end else if (r_ff.hcnt <= `GCC_OFS_CL_LO) begin
            nxt_r.cluster = {r_ff.cluster[7:0], rx_data};
          end else if (r_ff.hcnt <= `GCC_OFS_PR_LO) begin
            nxt_r.profile = {r_ff.profile[7:0], rx_data};
          end
          if (r_ff.hcnt < `GCC_OFS_ZCL) begin
            nxt_r.hcnt = r_ff.hcnt + 5'h01;
          end else begin
            unique case (r_ff.zlen)
              `GCC_ZCL_FC: nxt_r.fc = rx_data;
              `GCC_ZCL_SEQ: nxt_r.seq = rx_data;
              `GCC_ZCL_CMD: nxt_r.cmd = rx_data;
              `GCC_ZCL_GLO: nxt_r.glo = rx_data;
              `GCC_ZCL_GHI: nxt_r.ghi = rx_data;
              default: ;
            endcase
            if (r_ff.zlen != `GCC_ZCL_MAX) begin
              nxt_r.zlen = r_ff.zlen + 3'h1;
            end
          end
          if (rx_last) begin
            nxt_r.st = gcc_pkg::GCC_DECIDE;
          end
        end
      end
      gcc_pkg::GCC_DECIDE: begin
        nxt_r.hcnt = 5'h00;
        nxt_r.idx = '0;
        nxt_r.found = 1'b0;
        nxt_r.ocnt = 5'h00;
        nxt_r.rlen = `GCC_RLEN_DEFAULT;
        nxt_r.st = gcc_pkg::GCC_REPLY;
        // Frames for other clusters are not ours; dropped without reply
        if (r_ff.hcnt != `GCC_OFS_ZCL || r_ff.ftype != `GCC_API_EXPL_TX ||
            r_ff.cluster != `GCC_CLUSTER_GRP || r_ff.profile != `GCC_PROFILE) begin
          nxt_r.st = gcc_pkg::GCC_RECV;
        end else if (r_ff.zlen < `GCC_ZCL_HDR_LEN) begin
          nxt_r.rz = dflt_rsp(r_ff, `GCC_ST_MALFORMED);
        end else if (fc[`GCC_FC_TYPE_HI:`GCC_FC_TYPE_LO] != `GCC_FC_TYPE_CLUSTER) begin
          nxt_r.rz = dflt_rsp(r_ff, `GCC_ST_BAD_TYPE);
        end else if (fc[`GCC_FC_MFR_BIT]) begin
          nxt_r.rz = dflt_rsp(r_ff, `GCC_ST_BAD_MFR);
        end else if (fc[`GCC_FC_DIR_BIT]) begin
          nxt_r.rz = dflt_rsp(r_ff, `GCC_ST_BAD_CMD);
        end else if (r_ff.cmd != `GCC_CMD_REMOVE_ALL && r_ff.cmd != `GCC_CMD_REMOVE_GRP) begin
          nxt_r.rz = dflt_rsp(r_ff, `GCC_ST_BAD_CMD);
        end else if (r_ff.cmd == `GCC_CMD_REMOVE_GRP && r_ff.zlen < `GCC_ZCL_RMV_LEN) begin
          nxt_r.rz = dflt_rsp(r_ff, `GCC_ST_MALFORMED);
        end else if (r_ff.dst_ep == `GCC_EP_RESERVED) begin
          // Reserved endpoint owns no groups; removal is refused
          nxt_r.rz = dflt_rsp(r_ff, `GCC_ST_FAILURE);
        end else begin
          nxt_r.st = gcc_pkg::GCC_SCAN_RD;
        end
      end
      gcc_pkg::GCC_SCAN_RD: begin
        nxt_r.st = gcc_pkg::GCC_SCAN_CK;
      end
      gcc_pkg::GCC_SCAN_CK: begin
        match = tbl.rdata.valid && tbl.rdata.ep == r_ff.dst_ep &&
                (r_ff.cmd == `GCC_CMD_REMOVE_ALL ||
                 tbl.rdata.gid == {r_ff.ghi, r_ff.glo});
        if (match) begin
          tbl.we = 1'b1;
          tbl.waddr = r_ff.idx;
          tbl.wdata = '0;
          nxt_r.found = 1'b1;
        end
        if (r_ff.idx == `GCC_TBL_LAST) begin
          nxt_r.st = gcc_pkg::GCC_REPLY;
          if (r_ff.cmd == `GCC_CMD_REMOVE_ALL) begin
            nxt_r.rz = {`GCC_FC_RSP_CLUSTER, r_ff.seq, r_ff.cmd,
                        `GCC_ST_SUCCESS, 16'h0000};
            nxt_r.rlen = `GCC_RLEN_REMOVE_ALL;
          end else if (match || r_ff.found) begin
            nxt_r.rz = {`GCC_FC_RSP_CLUSTER, r_ff.seq, r_ff.cmd,
                        `GCC_ST_SUCCESS, r_ff.glo, r_ff.ghi};
            nxt_r.rlen = `GCC_RLEN_REMOVE_GRP;
          end else begin
            nxt_r.rz = dflt_rsp(r_ff, `GCC_ST_NOT_FOUND);
            nxt_r.rlen = `GCC_RLEN_DEFAULT;
          end
        end else begin
          nxt_r.idx = r_ff.idx + 4'h1;
          nxt_r.st = gcc_pkg::GCC_SCAN_RD;
        end
      end
      gcc_pkg::GCC_REPLY, gcc_pkg::GCC_STATUS: begin
        if (r_ff.st == gcc_pkg::GCC_REPLY) begin
          last = 5'(`GCC_RPL_HDR_LEN + 5'(r_ff.rlen) - 5'h01);
        end else begin
          last = `GCC_STAT_LAST;
        end
        if (!r_ff.tx_valid || tx_ready) begin
          if (r_ff.ocnt <= last) begin
            nxt_r.tx_valid = 1'b1;
            nxt_r.tx_last = (r_ff.ocnt == last);
            nxt_r.tx_data = (r_ff.st == gcc_pkg::GCC_REPLY) ? rpl_byte(r_ff, r_ff.ocnt) :
                            stat_byte(r_ff, r_ff.ocnt);
            nxt_r.ocnt = r_ff.ocnt + 5'h01;
          end else begin
            // Last byte accepted; only now may the status frame follow
            nxt_r.tx_valid = 1'b0;
            nxt_r.tx_last = 1'b0;
            nxt_r.ocnt = 5'h00;
            if (r_ff.st == gcc_pkg::GCC_REPLY && r_ff.tag != 8'h00 && tx_room) begin
              nxt_r.st = gcc_pkg::GCC_STATUS;
            end else begin
              nxt_r.st = gcc_pkg::GCC_RECV;
            end
          end
        end
      end
      default: nxt_r.st = gcc_pkg::GCC_RECV;
    endcase
    nxt_r.rx_ready = (nxt_r.st == gcc_pkg::GCC_RECV);
    nxt_r.add_ready = (nxt_r.st != gcc_pkg::GCC_SCAN_RD) && (nxt_r.st != gcc_pkg::GCC_SCAN_CK);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign rx_ready = r_ff.rx_ready;
  assign tx_valid = r_ff.tx_valid;
  assign tx_data = r_ff.tx_data;
  assign tx_last = r_ff.tx_last;
  assign add_ready = r_ff.add_ready;
endmodule : gcc_cmd_handler
`default_nettype wire

// ### hdl/gcc_group_table.sv
`include "gcc_defs.svh"
`default_nettype none
module gcc_group_table (
  input wire logic core_clk,
  input wire logic rst,
  gcc_tbl_if.mem port
);
  gcc_pkg::gcc_tbl_regs_t r_ff;
  gcc_pkg::gcc_tbl_regs_t nxt_r;

  // Read returns old contents on a same-address write
  always_comb begin
    nxt_r = r_ff;
    nxt_r.rd = r_ff.ent[port.raddr];
    if (port.we) begin
      nxt_r.ent[port.waddr] = port.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign port.rdata = r_ff.rd;
endmodule : gcc_group_table
`default_nettype wire

// ### inc/gcc_defs.svh
`ifndef GCC_DEFS_SVH
`define GCC_DEFS_SVH
// API frame types
`define GCC_API_EXPL_TX 8'h11
`define GCC_API_EXPL_RX 8'h91
`define GCC_API_TX_STAT 8'h8B
// Cluster and profile identifiers, unknown 16-bit address
`define GCC_CLUSTER_GRP 16'h0006
`define GCC_CLUSTER_GRP_RSP 16'h8006
`define GCC_PROFILE 16'hC105
`define GCC_ADDR16_UNKNOWN 16'hFFFE
// Request byte offsets inside the API frame body
`define GCC_OFS_TYPE 5'h00
`define GCC_OFS_TAG 5'h01
`define GCC_OFS_ADDR_LO 5'h02
`define GCC_OFS_ADDR_HI 5'h0B
`define GCC_OFS_SRC_EP 5'h0C
`define GCC_OFS_DST_EP 5'h0D
`define GCC_OFS_CL_HI 5'h0E
`define GCC_OFS_CL_LO 5'h0F
`define GCC_OFS_PR_HI 5'h10
`define GCC_OFS_PR_LO 5'h11
`define GCC_OFS_ZCL 5'h14
// Cluster-library byte positions and lengths in the payload
`define GCC_ZCL_FC 3'h0
`define GCC_ZCL_SEQ 3'h1
`define GCC_ZCL_CMD 3'h2
`define GCC_ZCL_GLO 3'h3
`define GCC_ZCL_GHI 3'h4
`define GCC_ZCL_MAX 3'h7
`define GCC_ZCL_HDR_LEN 3'h3
`define GCC_ZCL_RMV_LEN 3'h5
// Frame control fields
`define GCC_FC_TYPE_HI 1
`define GCC_FC_TYPE_LO 0
`define GCC_FC_MFR_BIT 2
`define GCC_FC_DIR_BIT 3
`define GCC_FC_TYPE_CLUSTER 2'h1
`define GCC_FC_RSP_CLUSTER 8'h09
`define GCC_FC_RSP_GENERAL 8'h08
// Command identifiers
`define GCC_CMD_REMOVE_GRP 8'h03
`define GCC_CMD_REMOVE_ALL 8'h04
`define GCC_CMD_DEFAULT_RSP 8'h03
// Status codes
`define GCC_ST_SUCCESS 8'h00
`define GCC_ST_FAILURE 8'h01
`define GCC_ST_MALFORMED 8'h80
`define GCC_ST_BAD_CMD 8'h81
`define GCC_ST_BAD_TYPE 8'h82
`define GCC_ST_BAD_MFR 8'h84
`define GCC_ST_NOT_FOUND 8'h8B
// Reply layout
`define GCC_RPL_HDR_LEN 5'h12
`define GCC_RPL_OPTIONS 8'h00
`define GCC_STAT_LAST 5'h06
`define GCC_STAT_ZERO 8'h00
`define GCC_RLEN_REMOVE_ALL 3'h4
`define GCC_RLEN_REMOVE_GRP 3'h6
`define GCC_RLEN_DEFAULT 3'h5
// Group table
`define GCC_TBL_DEPTH 16
`define GCC_TBL_AW 4
`define GCC_TBL_LAST 4'hF
`define GCC_EP_RESERVED 8'h00
`endif

// ### inc/gcc_pkg.sv
`include "gcc_defs.svh"
`default_nettype none
package gcc_pkg;
  typedef enum logic [2:0] {
    GCC_RECV, GCC_DECIDE, GCC_SCAN_RD, GCC_SCAN_CK, GCC_REPLY, GCC_STATUS
  } gcc_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] ep;
    logic [15:0] gid;
  } gcc_entry_t;

  typedef struct packed {
    gcc_entry_t [`GCC_TBL_DEPTH-1:0] ent;
    gcc_entry_t rd;
  } gcc_tbl_regs_t;

  typedef struct packed {
    gcc_state_t st;
    logic [4:0] hcnt;
    logic [2:0] zlen;
    logic [7:0] ftype;
    logic [7:0] tag;
    logic [79:0] addr;
    logic [7:0] src_ep;
    logic [7:0] dst_ep;
    logic [15:0] cluster;
    logic [15:0] profile;
    logic [7:0] fc;
    logic [7:0] seq;
    logic [7:0] cmd;
    logic [7:0] glo;
    logic [7:0] ghi;
    logic [`GCC_TBL_AW-1:0] idx;
    logic found;
    logic [47:0] rz;
    logic [2:0] rlen;
    logic [4:0] ocnt;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic add_ready;
  } gcc_regs_t;
endpackage : gcc_pkg
`default_nettype wire

// ### inc/gcc_tbl_if.sv
`include "gcc_defs.svh"
`default_nettype none
interface gcc_tbl_if;
  logic we;
  logic [`GCC_TBL_AW-1:0] waddr;
  gcc_pkg::gcc_entry_t wdata;
  logic [`GCC_TBL_AW-1:0] raddr;
  gcc_pkg::gcc_entry_t rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : gcc_tbl_if
`default_nettype wire

// ### tb/gcc_chk_assertions.sv
`include "gcc_defs.svh"
`default_nettype none
module gcc_chk_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] rx_pos_ff;
  logic [4:0] tx_pos_ff;
  logic [7:0] type_ff;
  logic [7:0] tag_ff;
  logic [7:0] src_ff;
  logic [7:0] dst_ff;
  logic [7:0] seq_ff;
  logic rsp;
  // Request fields need no reset: only read once a frame went through
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_pos_ff <= 5'h00;
      tx_pos_ff <= 5'h00;
      type_ff <= 8'h00;
    end else begin
      if (rx_valid && rx_ready) begin
        rx_pos_ff <= rx_last ? 5'h00 : rx_pos_ff + 5'h01;
        case (rx_pos_ff)
          5'h00: seq_ff <= 8'h00;
          5'h01: tag_ff <= rx_data;
          5'h0C: src_ff <= rx_data;
          5'h0D: dst_ff <= rx_data;
          5'h15: seq_ff <= rx_data;
          default: ;
        endcase
      end
      if (tx_valid && tx_ready) begin
        tx_pos_ff <= tx_last ? 5'h00 : tx_pos_ff + 5'h01;
        if (tx_pos_ff == 5'h00) type_ff <= tx_data;
      end
    end
  end
  assign rsp = tx_valid && type_ff == `GCC_API_EXPL_RX;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rx_end; rx_valid && rx_ready && rx_last; endsequence
  sequence s_tx_end; tx_valid && tx_ready && tx_last; endsequence
  sequence s_tx_wait; tx_valid && !tx_ready; endsequence
  a_rx_end_stall: assert property (s_rx_end |=> !rx_ready)
    else $error("rx_ready stayed high after frame end");
  a_tx_hold_stable: assert property (s_tx_wait |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed before it was taken");
  a_tx_frame_gap: assert property (s_tx_end |=> !tx_valid)
    else $error("no idle cycle after frame");
  a_frame_first_type: assert property (tx_valid && tx_pos_ff == 5'h00 |->
    tx_data == `GCC_API_EXPL_RX || tx_data == `GCC_API_TX_STAT)
    else $error("bad frame type byte");
  a_status_after_reply: assert property (tx_valid && tx_pos_ff == 5'h00 &&
    tx_data == `GCC_API_TX_STAT |-> type_ff == `GCC_API_EXPL_RX)
    else $error("status frame without reply before it");
  a_status_tag_echo: assert property (tx_valid && type_ff == `GCC_API_TX_STAT &&
    tx_pos_ff == 5'h01 |-> tx_data == tag_ff && tag_ff != 8'h00)
    else $error("status frame tag wrong");
  a_reply_ep_swap: assert property (rsp && tx_pos_ff inside {5'h0B, 5'h0C} |->
    tx_data == (tx_pos_ff == 5'h0B ? dst_ff : src_ff))
    else $error("reply endpoints not swapped");
  a_reply_cluster_id: assert property (rsp && tx_pos_ff inside {5'h0D, 5'h0E} |->
    tx_data == (tx_pos_ff == 5'h0D ? 8'h80 : 8'h06))
    else $error("reply cluster wrong");
  a_reply_seq_copy: assert property (rsp && tx_pos_ff == 5'h13 |-> tx_data == seq_ff)
    else $error("reply sequence not copied");
endmodule : gcc_chk_assertions
bind gcc_cmd_handler gcc_chk_assertions chk_u (.core_clk(core_clk), .rst(rst),
  .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
`default_nettype wire

// ### tb/gcc_host_model.sv
`default_nettype none
module gcc_host_model (
  input wire logic core_clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic tx_room,
  input wire logic slow,
  input wire logic room
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] got [$];
  assign tx_room = room;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b1;
  end
  // Slow sink toggles ready to stall every other cycle
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) got.push_back({tx_last, tx_data});
    #1;
    tx_ready = slow ? ~tx_ready : 1'b1;
  end
  // Whole frame, one byte held until taken
  task automatic send(input logic [7:0] b [$]);
    for (int i = 0; i < b.size(); i++) begin
      rx_valid = 1'b1;
      rx_data = b[i];
      rx_last = (i == b.size() - 1);
      do @(posedge core_clk); while (rx_ready !== 1'b1);
      #1;
    end
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data;
  endtask : send
endmodule : gcc_host_model
`default_nettype wire

// ### tb/tb.sv
`include "gcc_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [7:0] gcc_bq_t [$];
  typedef logic [8:0] gcc_nq_t [$];
  // Arbitrary test address
  localparam logic [63:0] ADDR64 = 64'h0123456789ABCDEF;
  logic core_clk = 1'b0;
  logic rst, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, tx_room;
  logic [7:0] rx_data;
  logic [7:0] tx_data;
  logic add_valid, add_ready, slow, room;
  logic [3:0] add_index;
  logic [7:0] add_ep;
  logic [15:0] add_gid;
  logic [15:0] cl_id;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  gcc_cmd_handler dut_u (.core_clk(core_clk), .rst(rst), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .tx_room(tx_room),
    .add_valid(add_valid), .add_index(add_index), .add_ep(add_ep), .add_gid(add_gid),
    .add_ready(add_ready));
  gcc_host_model host_u (.core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .tx_room(tx_room), .slow(slow), .room(room));
  always #12.5 core_clk = ~core_clk;
  task automatic test_done();
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic cmp(logic [8:0] g, logic [8:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  // Frame body, then the low rn bytes of rq, most significant first
  task automatic req(logic [7:0] tag, logic [7:0] dst, logic [47:0] rq, int rn);
    gcc_bq_t b;
    logic [159:0] h;
    h = {`GCC_API_EXPL_TX, tag, ADDR64, `GCC_ADDR16_UNKNOWN, 8'hE6, dst, cl_id,
         `GCC_PROFILE, 16'h0000};
    for (int i = 19; i >= 0; i--) b.push_back(h[i*8 +: 8]);
    for (int i = rn - 1; i >= 0; i--) b.push_back(rq[i*8 +: 8]);
    host_u.got.delete();
    host_u.send(b);
  endtask : req
  // Waits until frames are taken again, then compares every byte sent back
  task automatic fin(logic [7:0] tag, logic [7:0] dst, logic [47:0] ex, int en);
    gcc_nq_t e;
    logic [143:0] h;
    logic [55:0] s;
    h = {`GCC_API_EXPL_RX, ADDR64, `GCC_ADDR16_UNKNOWN, dst, 8'hE6, `GCC_CLUSTER_GRP_RSP,
         `GCC_PROFILE, `GCC_RPL_OPTIONS};
    s = {`GCC_API_TX_STAT, tag, `GCC_ADDR16_UNKNOWN, 24'h000000};
    if (en != 0) begin
      for (int i = 17; i >= 0; i--) e.push_back({1'b0, h[i*8 +: 8]});
      for (int i = en - 1; i >= 0; i--) e.push_back({i == 0, ex[i*8 +: 8]});
      if (tag != 8'h00 && room) begin
        for (int i = 6; i >= 0; i--) e.push_back({i == 0, s[i*8 +: 8]});
      end
    end
    do @(posedge core_clk); while (rx_ready !== 1'b1);
    #1;
    cmp(9'(host_u.got.size()), 9'(e.size()));
    for (int k = 0; k < e.size() && k < host_u.got.size(); k++) begin
      cmp(host_u.got[k], e[k]);
    end
  endtask : fin
  task automatic dc(logic [7:0] tag, logic [7:0] dst, logic [47:0] rq, int rn,
                    logic [47:0] ex, int en);
    req(tag, dst, rq, rn);
    fin(tag, dst, ex, en);
  endtask : dc
  task automatic add_ent(logic [3:0] idx, logic [7:0] ep, logic [15:0] gid);
    add_valid = 1'b1;
    add_index = idx;
    add_ep = ep;
    add_gid = gid;
    do @(posedge core_clk); while (add_ready !== 1'b1);
    #1;
    add_valid = 1'b0;
    @(posedge core_clk);
    #1;
  endtask : add_ent
  // Last table slot used so the scan end point is exercised
  task automatic t_remove_all();
    add_ent(4'h0, 8'hE7, 16'h1234);
    add_ent(4'h1, 8'hE8, 16'h5678);
    add_ent(4'hF, 8'hE7, 16'hABCD);
    req(8'h01, 8'hE7, 48'h01EE04, 3);
    repeat (3) @(posedge core_clk);
    #1;
    cmp({8'h00, add_ready}, 9'h000);
    fin(8'h01, 8'hE7, 48'h09EE0400, 4);
    dc(8'h02, 8'hE7, 48'h0111033412, 5, 48'h081103038B, 5);
    dc(8'h03, 8'hE7, 48'h011203CDAB, 5, 48'h081203038B, 5);
  endtask : t_remove_all
  task automatic t_remove_grp();
    slow = 1'b1;
    dc(8'h04, 8'hE8, 48'h0113037856, 5, 48'h091303007856, 6);
    dc(8'h05, 8'hE8, 48'h0114037856, 5, 48'h081403038B, 5);
    slow = 1'b0;
  endtask : t_remove_grp
  task automatic t_errors();
    dc(8'h00, 8'hE7, 48'h000000, 0, 48'h0800030080, 5);
    dc(8'h00, 8'hE7, 48'h002104, 3, 48'h0821030482, 5);
    dc(8'h00, 8'hE7, 48'h052204, 3, 48'h0822030484, 5);
    dc(8'h00, 8'hE7, 48'h092304, 3, 48'h0823030481, 5);
    dc(8'h00, 8'hE7, 48'h012407, 3, 48'h0824030781, 5);
    dc(8'h00, 8'hE7, 48'h01250334, 4, 48'h0825030380, 5);
    dc(8'h06, 8'h00, 48'h012604, 3, 48'h0826030401, 5);
  endtask : t_errors
  task automatic t_room_drop();
    room = 1'b0;
    dc(8'h07, 8'hE7, 48'h012804, 3, 48'h09280400, 4);
    room = 1'b1;
    cl_id = 16'h0008;
    dc(8'h08, 8'hE7, 48'h012904, 3, 48'h000000, 0);
    cl_id = `GCC_CLUSTER_GRP;
  endtask : t_room_drop
  // Mid-run reset must also empty the table
  task automatic t_reset();
    add_ent(4'h2, 8'hE9, 16'h2222);
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    cmp({6'h00, tx_valid, rx_ready, add_ready}, 9'h000);
    rst = 1'b0;
    @(posedge core_clk);
    #1;
    cmp({6'h00, tx_valid, rx_ready, add_ready}, 9'h003);
    dc(8'h09, 8'hE9, 48'h012A032222, 5, 48'h082A03038B, 5);
  endtask : t_reset
  initial begin
    rst = 1'b1;
    add_valid = 1'b0;
    add_index = 4'h0;
    add_ep = 8'h00;
    add_gid = 16'h0000;
    slow = 1'b0;
    room = 1'b1;
    cl_id = `GCC_CLUSTER_GRP;
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_remove_all();
    t_remove_grp();
    t_errors();
    t_room_drop();
    t_reset();
    test_done();
  end
endmodule : tb
`default_nettype wire
